// ### decoder_pkg.sv
// Constants, opcodes, register map and carrier types of the instruction decoder.
package decoder_pkg;

   // ----------------------------------------
   // Word layout
   // ----------------------------------------
   localparam int WORD_W = 14;
   localparam int FILE_W = 7;
   localparam int DATA_W = 8;
   localparam int PC_W = 11;
   localparam int CLS_LSB = 12;
   localparam int OP_LSB = 8;
   localparam int DEST_BIT = 7;
   localparam int BIT_IDX_LSB = 7;
   localparam int CALL_SEL_BIT = 11;
   localparam int NIB_W = 4;

   // ----------------------------------------
   // Instruction classes and opcodes
   // ----------------------------------------
   localparam logic [1:0] CLS_BYTE = 2'h0;
   localparam logic [1:0] CLS_BIT = 2'h1;
   localparam logic [1:0] CLS_JUMP = 2'h2;
   localparam logic [1:0] CLS_LIT = 2'h3;
   localparam logic [3:0] OP_MISC = 4'h0;
   localparam logic [3:0] OP_CLR = 4'h1;
   localparam logic [3:0] OP_SUB = 4'h2;
   localparam logic [3:0] OP_DEC = 4'h3;
   localparam logic [3:0] OP_IOR = 4'h4;
   localparam logic [3:0] OP_AND = 4'h5;
   localparam logic [3:0] OP_XOR = 4'h6;
   localparam logic [3:0] OP_ADD = 4'h7;
   localparam logic [3:0] OP_MOV = 4'h8;
   localparam logic [3:0] OP_COM = 4'h9;
   localparam logic [3:0] OP_INC = 4'ha;
   localparam logic [3:0] OP_DECSZ = 4'hb;
   localparam logic [3:0] OP_RR = 4'hc;
   localparam logic [3:0] OP_RL = 4'hd;
   localparam logic [3:0] OP_SWAP = 4'he;
   localparam logic [3:0] OP_INCSZ = 4'hf;
   localparam logic [1:0] BOP_CLR = 2'h0;
   localparam logic [1:0] BOP_SET = 2'h1;
   localparam logic [1:0] BOP_TSTC = 2'h2;
   localparam logic [1:0] BOP_TSTS = 2'h3;
   localparam logic [1:0] LOP_LOAD = 2'h0;
   localparam logic [1:0] LOP_RET = 2'h1;
   localparam logic [2:0] LOP_SUB = 3'h6;
   localparam logic [2:0] LOP_ADD = 3'h7;
   localparam logic [3:0] LOP_OR = 4'h8;
   localparam logic [3:0] LOP_AND = 4'h9;
   localparam logic [3:0] LOP_XOR = 4'ha;
   localparam logic [7:0] CTL_RETURN = 8'h08;
   localparam logic [7:0] CTL_INTERRUPT_RETURN_OP = 8'h09;
   localparam logic [7:0] CTL_SLEEP = 8'h63;
   localparam logic [7:0] CTL_WATCHDOG_CLEAR_OP = 8'h64;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int OSC_PER_CYCLE = 4;
   localparam logic [1:0] Q_LAST = 2'(OSC_PER_CYCLE - 1);

   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [7:0] REG_INSTR = 8'h00;
   localparam logic [7:0] REG_ACC = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_PC = 8'h0c;
   localparam logic [7:0] REG_FADDR = 8'h10;
   localparam logic [7:0] REG_FDATA = 8'h14;
   localparam logic [7:0] REG_CTRL = 8'h18;
   localparam int CTRL_PRESC_BIT = 0;
   localparam int CTRL_BUSY_BIT = 1;
   localparam int CTRL_SKIP_BIT = 2;

   typedef struct packed {
      logic watchdog_expired_flag;
      logic sleep_entered_flag;
      logic zero_flag;
      logic nibble_carry_flag;
      logic carry_flag;
   } status_type;

   localparam status_type STATUS_RESET = 5'h00;

   typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_NOP} exec_state_type;

endpackage

// ### instr_decoder.sv
// Fourteen-bit instruction decoder and executor with an APB register port.
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
// How it works
// RL1: File operand comes from the low seven word bits, addresses 0x00 to 0x7F.
// RL2: Byte operations write the accumulator when d is zero, the file when one.
// RL3: One 8-bit accumulator is the second operand of file and literal operations.
// RL4: Byte add, subtract, OR, AND decoded; add and subtract set C, DC, Z.
// RL5: XOR, complement, decrement, increment, move, swap and clear decoded as listed.
// RL6: Rotates go through carry, left 1101, right 1100, changing carry only.
// RL7: Decrement or increment then skip when the result is zero; no flags change.
// RL8: Bit words clear or set the indexed bit, flags untouched.
// RL9: Bit tests skip when the bit is clear or set respectively.
// RL10: Literal add and literal-minus-accumulator update carry, nibble carry and zero.
// RL11: Literal AND, OR and XOR with the accumulator update zero only.
// RL12: Literal load leaves flags; literal return loads and returns in two cycles.
// RL13: Call when bit 11 is zero, jump when one, both two cycles.
// RL14: Fixed words return from subroutine and from interrupt, two cycles each.
// RL15: Standby and watchdog clear words update timeout and power-down bits.
// RL16: Don't-care positions never change which operation is decoded.
// RL17: Port register self-modification reads the synchronised pin levels.
// RL18: Writing the timer count clears the prescaler when it is assigned there.
// RL19: One cycle normally; skips and program counter changes add a no-op cycle.
// RL20: Each instruction cycle spans four clock periods.
// RL21: The named file register is always read before it is written back.
// RL22: Zero flag is set when the affected 8-bit result is zero.
module instr_decoder
   import decoder_pkg::*;
#(
   parameter logic [FILE_W-1:0] TIMER_FILE = 7'h01,
   parameter logic [FILE_W-1:0] PORT_FILE = 7'h05,
   parameter int STACK_DEPTH = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [DATA_W-1:0] port_pins,
   output logic prescaler_clear,
   output logic watchdog_clear,
   output logic sleep_request,
   output logic busy
);

   localparam int SP_W = $clog2(STACK_DEPTH);

   // ----------------------------------------
   // State
   // ----------------------------------------
   logic [DATA_W-1:0] file_mem [2**FILE_W];
   logic [PC_W-1:0] stack_mem [STACK_DEPTH];
   logic [SP_W-1:0] sp_r;
   logic [WORD_W-1:0] ir_r;
   logic [DATA_W-1:0] acc_r;
   status_type status_r;
   logic [PC_W-1:0] pc_r;
   logic [FILE_W-1:0] faddr_r;
   logic presc_assigned_r;
   logic skip_r;
   logic [1:0] q_r;
   exec_state_type state_r;
   exec_state_type state_nxt;
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   logic presc_clr_r;
   logic wdt_clr_r;
   logic sleep_r;
   logic busy_r;
   logic [DATA_W-1:0] pins_meta_r;
   logic [DATA_W-1:0] pins_sync_r;

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   wire access = psel & penable & ~pready_r & ~busy_r;
   wire take = psel & penable & pready_r;
   wire wr_take = take & pwrite;
   wire hit = (paddr == REG_INSTR) | (paddr == REG_ACC) | (paddr == REG_STATUS) |
              (paddr == REG_PC) | (paddr == REG_FADDR) | (paddr == REG_FDATA) |
              (paddr == REG_CTRL);
   wire wr_instr = wr_take & (paddr == REG_INSTR);
   wire wr_acc_bus = wr_take & (paddr == REG_ACC);
   wire wr_stat_bus = wr_take & (paddr == REG_STATUS);
   wire wr_pc_bus = wr_take & (paddr == REG_PC);
   wire wr_faddr_bus = wr_take & (paddr == REG_FADDR);
   wire wr_fdata_bus = wr_take & (paddr == REG_FDATA);
   wire wr_ctrl_bus = wr_take & (paddr == REG_CTRL);

   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = '0;
      case (paddr)
         REG_INSTR: rd_mux = 32'(ir_r);
         REG_ACC: rd_mux = 32'(acc_r);
         REG_STATUS: rd_mux = 32'(status_r);
         REG_PC: rd_mux = 32'(pc_r);
         REG_FADDR: rd_mux = 32'(faddr_r);
         REG_FDATA: rd_mux = 32'(file_mem[faddr_r]);
         REG_CTRL: begin
            rd_mux[CTRL_PRESC_BIT] = presc_assigned_r;
            rd_mux[CTRL_BUSY_BIT] = busy_r;
            rd_mux[CTRL_SKIP_BIT] = skip_r;
         end
         default: rd_mux = '0;
      endcase
   end

   // ----------------------------------------
   // Operand fields
   // ----------------------------------------
   wire [1:0] cls = ir_r[CLS_LSB +: 2];
   wire [3:0] op = ir_r[OP_LSB +: 4];
   wire [FILE_W-1:0] f_addr = ir_r[FILE_W-1:0]; // RL1
   wire dest_f = ir_r[DEST_BIT];
   wire [2:0] bit_idx = ir_r[BIT_IDX_LSB +: 3];
   wire [DATA_W-1:0] lit = ir_r[DATA_W-1:0];
   wire [PC_W-1:0] target = ir_r[PC_W-1:0];
   // A port read returns the pin levels, not the latch, so a read-back keeps what the pins show.
   wire [DATA_W-1:0] f_val = (f_addr == PORT_FILE) ? pins_sync_r : file_mem[f_addr]; // RL17 RL21
   wire [DATA_W-1:0] bit_mask = DATA_W'(1) << bit_idx;
   wire bit_val = |(f_val & bit_mask);

   // Shared adder: literal class uses k, byte class uses the file value.
   wire is_sub = (cls == CLS_LIT) ? (ir_r[OP_LSB+1 +: 3] == LOP_SUB) : (op == OP_SUB);
   wire [DATA_W-1:0] opa = (cls == CLS_LIT) ? lit : f_val;
   wire [DATA_W-1:0] opb = is_sub ? ~acc_r : acc_r; // RL3
   wire [DATA_W:0] sum = {1'b0, opa} + {1'b0, opb} + (DATA_W+1)'(is_sub);
   wire [NIB_W:0] nib = {1'b0, opa[NIB_W-1:0]} + {1'b0, opb[NIB_W-1:0]} +
                        (NIB_W+1)'(is_sub);

   // ----------------------------------------
   // Execute
   // ----------------------------------------
   logic [DATA_W-1:0] res;
   logic to_acc;
   logic to_file;
   logic upd_c;
   logic upd_dc;
   logic upd_z;
   logic c_new;
   logic skip;
   logic jump;
   logic push;
   logic pop;
   logic do_sleep;
   logic do_wdt;

   always_comb begin
      res = '0;
      to_acc = 1'b0;
      to_file = 1'b0;
      upd_c = 1'b0;
      upd_dc = 1'b0;
      upd_z = 1'b0;
      c_new = sum[DATA_W];
      skip = 1'b0;
      jump = 1'b0;
      push = 1'b0;
      pop = 1'b0;
      do_sleep = 1'b0;
      do_wdt = 1'b0;
      case (cls)
         CLS_BYTE: begin
            to_acc = ~dest_f; // RL2
            to_file = dest_f; // RL2
            case (op)
               OP_ADD, OP_SUB: begin
                  res = sum[DATA_W-1:0]; // RL4
                  upd_c = 1'b1;
                  upd_dc = 1'b1;
                  upd_z = 1'b1;
               end
               OP_IOR: begin
                  res = f_val | acc_r; // RL4
                  upd_z = 1'b1;
               end
               OP_AND: begin
                  res = f_val & acc_r; // RL4
                  upd_z = 1'b1;
               end
               OP_XOR: begin
                  res = f_val ^ acc_r; // RL5
                  upd_z = 1'b1;
               end
               OP_COM: begin
                  res = ~f_val; // RL5
                  upd_z = 1'b1;
               end
               OP_DEC, OP_DECSZ: begin
                  res = f_val - DATA_W'(1); // RL5
                  upd_z = (op == OP_DEC);
                  skip = (op == OP_DECSZ) & (res == '0); // RL7
               end
               OP_INC, OP_INCSZ: begin
                  res = f_val + DATA_W'(1); // RL5
                  upd_z = (op == OP_INC);
                  skip = (op == OP_INCSZ) & (res == '0); // RL7
               end
               OP_MOV: begin
                  res = f_val; // RL5
                  upd_z = 1'b1;
               end
               OP_SWAP: begin
                  res = {f_val[NIB_W-1:0], f_val[DATA_W-1:NIB_W]}; // RL5
               end
               OP_CLR: begin
                  res = '0; // RL5
                  upd_z = 1'b1;
               end
               OP_RL: begin
                  res = {f_val[DATA_W-2:0], status_r.carry_flag}; // RL6
                  c_new = f_val[DATA_W-1];
                  upd_c = 1'b1;
               end
               OP_RR: begin
                  res = {status_r.carry_flag, f_val[DATA_W-1:1]}; // RL6
                  c_new = f_val[0];
                  upd_c = 1'b1;
               end
               OP_MISC: begin
                  res = acc_r;
                  to_acc = 1'b0;
                  // Only the listed low bytes act; other patterns with bit 7 clear are no-ops, bit 7 set stores the accumulator.
                  case (ir_r[DATA_W-1:0]) // RL16
                     CTL_RETURN, CTL_INTERRUPT_RETURN_OP: pop = 1'b1; // RL14
                     CTL_SLEEP: do_sleep = 1'b1; // RL15
                     CTL_WATCHDOG_CLEAR_OP: do_wdt = 1'b1; // RL15
                     default: ;
                  endcase
               end
               default: ;
            endcase
         end
         CLS_BIT: begin
            case (ir_r[OP_LSB+2 +: 2])
               BOP_CLR: begin
                  res = f_val & ~bit_mask; // RL8
                  to_file = 1'b1;
               end
               BOP_SET: begin
                  res = f_val | bit_mask; // RL8
                  to_file = 1'b1;
               end
               BOP_TSTC: skip = ~bit_val; // RL9
               BOP_TSTS: skip = bit_val; // RL9
               default: ;
            endcase
         end
         CLS_JUMP: begin
            jump = 1'b1; // RL13
            push = ~ir_r[CALL_SEL_BIT]; // RL13
         end
         default: begin
            to_acc = 1'b1;
            res = lit;
            if (ir_r[OP_LSB+1 +: 3] == LOP_ADD || ir_r[OP_LSB+1 +: 3] == LOP_SUB) begin
               res = sum[DATA_W-1:0]; // RL10
               upd_c = 1'b1;
               upd_dc = 1'b1;
               upd_z = 1'b1;
            end else if (op == LOP_OR) begin
               res = lit | acc_r; // RL11
               upd_z = 1'b1;
            end else if (op == LOP_AND) begin
               res = lit & acc_r; // RL11
               upd_z = 1'b1;
            end else if (op == LOP_XOR) begin
               res = lit ^ acc_r; // RL11
               upd_z = 1'b1;
            end else if (ir_r[OP_LSB+2 +: 2] == LOP_RET) begin
               pop = 1'b1; // RL12
            end else if (ir_r[OP_LSB+2 +: 2] == LOP_LOAD) begin
               res = lit; // RL12
            end else begin
               to_acc = 1'b0;
            end
         end
      endcase
      // Store-accumulator shares the misc opcode; bit 7 picks it.
      if (cls == CLS_BYTE && op == OP_MISC) begin
         to_file = dest_f;
      end
   end

   wire two_cycle = skip | jump | pop; // RL19
   wire commit = (state_r == ST_EXEC) & (q_r == Q_LAST); // RL20
   wire [SP_W-1:0] sp_dec = sp_r - SP_W'(1);
   wire [PC_W-1:0] pc_inc = pc_r + PC_W'(1);
   wire [PC_W-1:0] pc_next = pop ? stack_mem[sp_dec] :
                             jump ? target :
                             skip ? pc_r + PC_W'(2) : pc_inc; // RL19

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: if (wr_instr) state_nxt = ST_EXEC;
         ST_EXEC: if (q_r == Q_LAST) state_nxt = two_cycle ? ST_NOP : ST_IDLE; // RL19
         ST_NOP: if (q_r == Q_LAST) state_nxt = ST_IDLE;
         default: state_nxt = ST_IDLE;
      endcase
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pins_meta_r <= '0;
         pins_sync_r <= '0;
      end else begin
         pins_meta_r <= port_pins;
         pins_sync_r <= pins_meta_r;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= '0;
      end else begin
         pready_r <= access;
         pslverr_r <= access & ~hit;
         if (access) prdata_r <= rd_mux;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= ST_IDLE;
         q_r <= '0;
         busy_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         q_r <= (state_r == ST_IDLE) ? '0 : q_r + 2'(1); // RL20
         busy_r <= (state_nxt != ST_IDLE);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ir_r <= '0;
         acc_r <= '0;
         status_r <= STATUS_RESET;
         pc_r <= '0;
         faddr_r <= '0;
         presc_assigned_r <= 1'b0;
         skip_r <= 1'b0;
         sp_r <= '0;
      end else if (commit) begin
         if (to_acc) acc_r <= res; // RL2
         if (upd_c) status_r.carry_flag <= c_new; // RL4
         if (upd_dc) status_r.nibble_carry_flag <= nib[NIB_W]; // RL4
         if (upd_z) status_r.zero_flag <= (res == '0); // RL22
         if (do_sleep) begin
            status_r.sleep_entered_flag <= 1'b1; // RL15
            status_r.watchdog_expired_flag <= 1'b0;
         end
         if (do_wdt) begin
            status_r.sleep_entered_flag <= 1'b0; // RL15
            status_r.watchdog_expired_flag <= 1'b0;
         end
         pc_r <= pc_next;
         skip_r <= skip;
         if (push) sp_r <= sp_r + SP_W'(1); // RL13
         if (pop) sp_r <= sp_dec; // RL14
      end else begin
         if (wr_instr) ir_r <= pwdata[WORD_W-1:0];
         if (wr_acc_bus) acc_r <= pwdata[DATA_W-1:0];
         if (wr_stat_bus) status_r <= pwdata[$bits(status_type)-1:0];
         if (wr_pc_bus) pc_r <= pwdata[PC_W-1:0];
         if (wr_faddr_bus) faddr_r <= pwdata[FILE_W-1:0];
         if (wr_ctrl_bus) presc_assigned_r <= pwdata[CTRL_PRESC_BIT];
      end
   end

   // The stack wraps silently when over-filled; software must respect its depth.
   always_ff @(posedge pclk) begin
      if (commit && push) stack_mem[sp_r] <= pc_inc;
      if (commit && to_file) file_mem[f_addr] <= res; // RL2 RL21
      else if (wr_fdata_bus) file_mem[faddr_r] <= pwdata[DATA_W-1:0];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         presc_clr_r <= 1'b0;
         wdt_clr_r <= 1'b0;
         sleep_r <= 1'b0;
      end else begin
         presc_clr_r <= commit & to_file & (f_addr == TIMER_FILE) & presc_assigned_r; // RL18
         wdt_clr_r <= commit & do_wdt; // RL15
         sleep_r <= commit & do_sleep; // RL15
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign prescaler_clear = presc_clr_r;
   assign watchdog_clear = wdt_clr_r;
   assign sleep_request = sleep_r;
   assign busy = busy_r;

endmodule

// ### instr_decoder_sva.sv
// Checker of bus handshake, execution timing and the watchdog clear and standby pulse outputs of the decoder.
`timescale 1ns/1ps
module instr_decoder_chk
   import decoder_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [DATA_W-1:0] port_pins,
   input wire logic prescaler_clear,
   input wire logic watchdog_clear,
   input wire logic sleep_request,
   input wire logic busy
);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence one_cycle;
      busy [*4];
   endsequence
   a_ready_one_wait: assert property (psel && penable && !pready && !busy |=> pready)
      else $error("access not answered after one wait state");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   a_err_unmapped: assert property (pready |-> (pslverr == (paddr > REG_CTRL || paddr[1:0] != 2'h0)))
      else $error("error flag does not match address map");
   a_err_zero_data: assert property (pslverr && !pwrite |-> prdata == 32'h0000_0000)
      else $error("refused read returns data");
   a_busy_start: assert property (pready && pwrite && paddr == REG_INSTR |=> busy)
      else $error("instruction write did not start execution");
   a_busy_length: assert property ($rose(busy) |-> one_cycle ##1 (!busy or (one_cycle ##1 !busy)))
      else $error("execution not four or eight clocks");
   a_stall_busy: assert property (busy |-> !pready)
      else $error("bus answered during execution");
   a_watch_pulse: assert property (watchdog_clear |=> !watchdog_clear && !sleep_request)
      else $error("watchdog clear pulse malformed");
   a_sleep_pulse: assert property (sleep_request |-> !watchdog_clear ##1 !sleep_request)
      else $error("standby pulse malformed");
endmodule
bind instr_decoder instr_decoder_chk chk (
   .pclk(pclk),
   .presetn(presetn),
   .psel(psel),
   .penable(penable),
   .pwrite(pwrite),
   .paddr(paddr),
   .pwdata(pwdata),
   .prdata(prdata),
   .pready(pready),
   .pslverr(pslverr),
   .port_pins(port_pins),
   .prescaler_clear(prescaler_clear),
   .watchdog_clear(watchdog_clear),
   .sleep_request(sleep_request),
   .busy(busy)
);

// ### prog_rom.sv
// Program store that hands instruction words to the bench by address.
`timescale 1ns/1ps
module prog_rom
   import decoder_pkg::*;
(
   input wire logic [PC_W-1:0] addr,
   output logic [WORD_W-1:0] word
);
   // ----------------------------------------
   // Program
   // ----------------------------------------
   // Words behind a taken skip load a value that would spoil the accumulator if run.
   always_comb begin
      case (addr)
         11'h000: word = 14'h30F8;
         11'h001: word = 14'h3E08;
         11'h002: word = 14'h3355;
         11'h003: word = 14'h3C50;
         11'h004: word = 14'h390F;
         11'h005: word = 14'h3A0B;
         11'h006: word = 14'h3880;
         11'h007: word = 14'h00A0;
         11'h008: word = 14'h07A0;
         11'h009: word = 14'h3001;
         11'h00A: word = 14'h00A1;
         11'h00B: word = 14'h0BA1;
         11'h00C: word = 14'h30EE;
         11'h00D: word = 14'h2820;
         11'h020: word = 14'h0064;
         11'h021: word = 14'h0063;
         11'h022: word = 14'h0805;
         11'h023: word = 14'h0081;
         11'h024: word = 14'h17A1;
         11'h025: word = 14'h1FA1;
         11'h026: word = 14'h30EE;
         11'h027: word = 14'h2030;
         11'h030: word = 14'h0C21;
         11'h031: word = 14'h0E21;
         11'h032: word = 14'h0008;
         default: word = 14'h0000;
      endcase
   end
endmodule

// ### tb_fourteen_bit_instruction_decoder.sv
// Self-checking bench of the decoder running a program from the program store.
`timescale 1ns/1ps
module tb_fourteen_bit_instruction_decoder
   import decoder_pkg::*;
();
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, busy;
   logic prescaler_clear, watchdog_clear, sleep_request;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [DATA_W-1:0] port_pins;
   logic [PC_W-1:0] fetch_addr;
   logic [WORD_W-1:0] fetch_word;
   int n_mismatch, tests_run, n_wd, n_sl, n_pc;
   instr_decoder dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .port_pins(port_pins), .prescaler_clear(prescaler_clear),
      .watchdog_clear(watchdog_clear), .sleep_request(sleep_request), .busy(busy));
   prog_rom rom (.addr(fetch_addr), .word(fetch_word));
   always #25 pclk = ~pclk;
   always @(posedge pclk) begin
      if (watchdog_clear === 1'b1) n_wd++;
      if (sleep_request === 1'b1) n_sl++;
      if (prescaler_clear === 1'b1) n_pc++;
   end
   // ----------------------------------------
   // Bus and check tasks
   // ----------------------------------------
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] q, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      logic e;
      apb(1'b0, a, 32'h0000_0000, q, e);
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      tests_run++;
      if (g !== x) begin
         n_mismatch++;
         $display("FAIL t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask
   task automatic step(input logic [7:0] ea, input logic [4:0] es, input logic [10:0] ep,
      input int ec);
      logic [31:0] q;
      int n;
      n = 0;
      rd(REG_PC, q);
      fetch_addr = q[PC_W-1:0];
      #1;
      wr(REG_INSTR, {18'h0_0000, fetch_word});
      for (int i = 0; i < 20 && !(n > 0 && busy === 1'b0); i++) begin
         @(posedge pclk);
         if (busy === 1'b1) n++;
      end
      chk(32'(n), 32'(ec));
      rd(REG_ACC, q);
      chk(q, {24'h00_0000, ea});
      rd(REG_STATUS, q);
      chk(q, {27'h000_0000, es});
      rd(REG_PC, q);
      chk(q, {21'h00_0000, ep});
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_literal;
      step(8'hF8, 5'h00, 11'h001, 4);
      step(8'h00, 5'h07, 11'h002, 4);
      step(8'h55, 5'h07, 11'h003, 4);
      step(8'hFB, 5'h00, 11'h004, 4);
      step(8'h0B, 5'h00, 11'h005, 4);
      step(8'h00, 5'h04, 11'h006, 4);
      step(8'h80, 5'h00, 11'h007, 4);
   endtask
   task automatic t_file_skip;
      logic [31:0] q;
      step(8'h80, 5'h00, 11'h008, 4);
      step(8'h80, 5'h05, 11'h009, 4);
      step(8'h01, 5'h05, 11'h00A, 4);
      step(8'h01, 5'h05, 11'h00B, 4);
      step(8'h01, 5'h05, 11'h00D, 8);
      step(8'h01, 5'h05, 11'h020, 8);
      wr(REG_FADDR, 32'h0000_0020);
      rd(REG_FDATA, q);
      chk(q, 32'h0000_0000);
   endtask
   task automatic t_control;
      logic [31:0] q;
      wr(REG_CTRL, 32'h0000_0001);
      step(8'h01, 5'h05, 11'h021, 4);
      chk(32'(n_wd), 32'h0000_0001);
      step(8'h01, 5'h0D, 11'h022, 4);
      chk(32'(n_sl), 32'h0000_0001);
      step(8'hA5, 5'h09, 11'h023, 4);
      step(8'hA5, 5'h09, 11'h024, 4);
      chk(32'(n_pc), 32'h0000_0001);
      step(8'hA5, 5'h09, 11'h025, 4);
      step(8'hA5, 5'h09, 11'h027, 8);
      wr(REG_FADDR, 32'h0000_0021);
      rd(REG_FDATA, q);
      chk(q, 32'h0000_0080);
      rd(REG_CTRL, q);
      chk(q, 32'h0000_0005);
      step(8'hA5, 5'h09, 11'h030, 8);
      step(8'hC0, 5'h08, 11'h031, 4);
      step(8'h08, 5'h08, 11'h032, 4);
      step(8'h08, 5'h08, 11'h028, 8);
   endtask
   task automatic t_bus_err;
      logic [31:0] q;
      logic e;
      apb(1'b0, 8'h40, 32'h0000_0000, q, e);
      chk({31'h0, e}, 32'h0000_0001);
      chk(q, 32'h0000_0000);
   endtask
   // ----------------------------------------
   // Run control
   // ----------------------------------------
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      port_pins = 8'hA5;
      fetch_addr = 11'h000;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_literal();
      t_file_skip();
      t_control();
      t_bus_err();
      end_sim();
   end
   // A hang in any wait loop ends here instead of running forever.
   initial begin
      #400000;
      n_mismatch++;
      end_sim();
   end
endmodule
